// ---- core/iwc_ctrl.sv ----
// Added by the designer: the Avalon-MM slave port and the register addresses.
`include "iwc_cfg.svh"
// Function
// - each request line has its own enable bit in the mask register
// - flags set only by hardware; cleared only by software write of flag register
// - pin flags set on rising, falling or both edges per edge select
// - global enable set and cleared by instructions gates all lines
// - on interrupt, store program counter at stack pointer, then add two
// - on interrupt, global enable is cleared automatically
// - on interrupt, next fetch comes from vector 0x010
// - flags set even when their enable bit is zero
// - return reloads counter from stack, subtracts two, re-enables global enable
// - push and pop of working register and flags use two stack bytes
// - power-save stops only system clock; oscillators keep running, memory off
// - in power-save timers stop on system clock or disabled oscillator
// - power-down stops all oscillators and program memory, keeps contents
// - power-save wakes on enabled pin toggle or any of three timers
// - power-down wakes only on pin toggles
// - after pin wake-up execution resumes after the sleep instruction
// - normal wake-up resumes after 3000 low-speed oscillator periods
// - fast wake-up resumes after 45 low-speed oscillator periods
// - fast boot option forces fast wake-up, else aux bit 5 selects
// - mask bit 6 timer two, bit 5 pwm generator, bit 4 comparator
module iwc_ctrl #(
  parameter int NPIN = 8,
  parameter bit FAST_BOOT = 1'b0,
  parameter int WAKE_W = 12
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt sources; pins asynchronous, peripheral events on this clock
  input wire logic [1:0] ext_pin,
  input wire logic [NPIN-1:0] wake_pin,
  input wire logic t16_event,
  input wire logic cmp_event,
  input wire logic led_pwm_generator_event,
  input wire logic t2_event,
  input wire logic t3_event,
  input wire logic lrc_tick,
  // processor core side
  input wire iwc_pkg::iwc_cpu_cmd_t cpu_cmd,
  input wire logic [15:0] cpu_pc,
  input wire logic [7:0] cpu_acc,
  input wire logic [7:0] cpu_flags,
  input wire logic [15:0] mem_rdata,
  output logic irq_take,
  output logic [15:0] vector_pc,
  output iwc_pkg::iwc_mem_wr_t mem_wr,
  output logic [7:0] mem_raddr,
  output logic [15:0] pc_load,
  output logic pc_load_en,
  // clock and power control
  output logic sys_clk_en,
  output logic osc_en,
  output logic prog_mem_on,
  output logic timers_run_lrc
);
  import iwc_pkg::*;

  // registers
  logic [7:0] req_reg, req_next;
  logic [7:0] mask_reg;
  logic [7:0] edge_reg;
  logic [7:0] aux_reg;
  logic [7:0] sp_reg, sp_next;
  logic [NPIN-1:0] die_reg;
  logic gie_reg;
  logic [1:0] ext_s1_reg, ext_s2_reg, ext_d_reg;
  logic [NPIN-1:0] wp_s1_reg, wp_s2_reg, wp_d_reg;
  iwc_pwr_t pwr_reg, pwr_next;
  logic [WAKE_W-1:0] wcnt_reg;
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic wait_reg;
  logic irq_take_reg;
  iwc_mem_wr_t mem_wr_reg;
  logic [7:0] mem_raddr_reg;
  logic [15:0] pc_load_reg;
  logic pc_load_en_reg;
  logic [1:0] pop_stage_reg;
  logic push_stage_reg;

  // bus decode; answer one cycle after the request
  wire bus_req = (avs_read | avs_write) & ~ack_reg;
  wire wr_en = avs_write & ~ack_reg & avs_byteenable[0];
  wire wr_req = wr_en & (avs_address == `IWC_ADDR_REQ);
  wire wr_mask = wr_en & (avs_address == `IWC_ADDR_MASK);
  wire wr_edge = wr_en & (avs_address == `IWC_ADDR_EDGE);
  wire wr_aux = wr_en & (avs_address == `IWC_ADDR_AUX);
  wire wr_sp = wr_en & (avs_address == `IWC_ADDR_SP);
  wire wr_die = wr_en & (avs_address == `IWC_ADDR_DIE);

  // edge detection on synchronised pins; edge reg bits [1:0] pin0, [3:2] pin1
  wire [1:0] ext_rise = ext_s2_reg & ~ext_d_reg;
  wire [1:0] ext_fall = ~ext_s2_reg & ext_d_reg;
  wire [1:0] ext_hit;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_edge
      // 00 both edges, 01 rising, 10 falling, 11 both
      assign ext_hit[g] = (ext_rise[g] & (edge_reg[2*g+1:2*g] != `IWC_EDGE_FALL)) |
                          (ext_fall[g] & (edge_reg[2*g+1:2*g] != `IWC_EDGE_RISE));
    end
  endgenerate

  // event vector: 0,1 pins, 2 sixteen_bit_timer, 3 timer3, 4 comparator, 5 led_pwm_generator, 6 eight_bit_timer_two
  wire [7:0] ev = {1'b0, t2_event, led_pwm_generator_event, cmp_event, t3_event, t16_event, ext_hit};
  // events land regardless of mask; a set in the clear cycle wins
  assign req_next = (wr_req ? (req_reg & avs_writedata[7:0]) : req_reg) | ev;

  // interrupt decision at an instruction boundary (core ack strobe)
  wire pending = |(req_reg & mask_reg);
  wire in_on = (pwr_reg == IWC_ON);
  wire take = gie_reg & pending & in_on & cpu_cmd.take_ack;

  // wake sources; pin toggle on any input with its digital enable set
  wire pin_toggle = |((wp_s2_reg ^ wp_d_reg) & die_reg);
  wire timer_wake = t16_event | t2_event | t3_event;
  wire fast_wake = FAST_BOOT | aux_reg[`IWC_AUX_FAST_BIT];
  wire [WAKE_W-1:0] wake_len = fast_wake ? WAKE_W'(`IWC_WAKE_FAST) :
                                           WAKE_W'(`IWC_WAKE_NORMAL);

  // stack pointer arithmetic
  wire do_push = take | cpu_cmd.push_flags;
  wire do_pop = cpu_cmd.ret | cpu_cmd.pop_flags;
  assign sp_next = wr_sp ? avs_writedata[7:0] :
                   do_push ? sp_reg + `IWC_SP_STEP :
                   do_pop ? sp_reg - `IWC_SP_STEP : sp_reg;

  // power state machine
  always_comb begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      IWC_ON: begin
        if (cpu_cmd.power_down) pwr_next = IWC_DOWN;
        else if (cpu_cmd.power_save) pwr_next = IWC_SAVE;
      end
      IWC_SAVE: if (pin_toggle | timer_wake) pwr_next = IWC_WAKE;
      IWC_DOWN: if (pin_toggle) pwr_next = IWC_WAKE;
      IWC_WAKE: if (wcnt_reg == '0) pwr_next = IWC_ON;
      default: pwr_next = IWC_ON;
    endcase
  end

  // register file writes
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      req_reg <= 8'h00;
      mask_reg <= 8'h00;
      edge_reg <= 8'h00;
      aux_reg <= `IWC_RST_AUX;
      die_reg <= '0;
      sp_reg <= `IWC_RST_SP;
    end else begin
      req_reg <= req_next;
      if (wr_mask) mask_reg <= avs_writedata[7:0];
      if (wr_edge) edge_reg <= avs_writedata[7:0];
      if (wr_aux) aux_reg <= avs_writedata[7:0];
      if (wr_die) die_reg <= avs_writedata[NPIN-1:0];
      sp_reg <= sp_next;
    end
  end

  // global enable: entry clears it, return sets it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) gie_reg <= 1'b0;
    else if (take | cpu_cmd.global_off) gie_reg <= 1'b0;
    else if (cpu_cmd.ret | cpu_cmd.global_on) gie_reg <= 1'b1;
  end

  // two-flop synchronisers plus edge history for asynchronous pins
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ext_s1_reg <= 2'h0;
      ext_s2_reg <= 2'h0;
      ext_d_reg <= 2'h0;
      wp_s1_reg <= '0;
      wp_s2_reg <= '0;
      wp_d_reg <= '0;
    end else begin
      ext_s1_reg <= ext_pin;
      ext_s2_reg <= ext_s1_reg;
      ext_d_reg <= ext_s2_reg;
      wp_s1_reg <= wake_pin;
      wp_s2_reg <= wp_s1_reg;
      wp_d_reg <= wp_s2_reg;
    end
  end

  // power state and wake-up counter, counted in low-speed ticks
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pwr_reg <= IWC_ON;
      wcnt_reg <= '0;
    end else begin
      pwr_reg <= pwr_next;
      if (pwr_reg != IWC_WAKE && pwr_next == IWC_WAKE) wcnt_reg <= wake_len;
      else if (pwr_reg == IWC_WAKE && lrc_tick && wcnt_reg != '0)
        wcnt_reg <= wcnt_reg - WAKE_W'(1);
    end
  end

  // clock gating outputs: save keeps oscillators, down stops them
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sys_clk_en <= 1'b1;
      osc_en <= 1'b1;
      prog_mem_on <= 1'b1;
      timers_run_lrc <= 1'b1;
    end else begin
      sys_clk_en <= (pwr_next == IWC_ON);
      osc_en <= (pwr_next != IWC_DOWN);
      prog_mem_on <= (pwr_next == IWC_ON);
      timers_run_lrc <= (pwr_next != IWC_DOWN);
    end
  end

  // stack traffic: entry and push write, return and pop set the read address, only return then loads
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_take_reg <= 1'b0;
      mem_wr_reg <= '0;
      mem_raddr_reg <= 8'h00;
      pc_load_reg <= 16'h0000;
      pc_load_en_reg <= 1'b0;
      pop_stage_reg <= 2'h0;
      push_stage_reg <= 1'b0;
    end else begin
      irq_take_reg <= take;
      mem_wr_reg.we <= take | cpu_cmd.push_flags | push_stage_reg;
      push_stage_reg <= take | cpu_cmd.push_flags;
      if (take) begin
        mem_wr_reg.addr <= sp_reg;
        mem_wr_reg.data <= cpu_pc[7:0];
        pc_load_reg <= `IWC_VECTOR;
      end else if (cpu_cmd.push_flags) begin
        mem_wr_reg.addr <= sp_reg;
        mem_wr_reg.data <= cpu_acc;
      end else if (push_stage_reg) begin
        mem_wr_reg.addr <= mem_wr_reg.addr + 8'h01;
        mem_wr_reg.data <= irq_take_reg ? cpu_pc[15:8] : cpu_flags;
      end
      if (do_pop) mem_raddr_reg <= sp_reg - `IWC_SP_STEP;
      pop_stage_reg <= {pop_stage_reg[0] & 1'b0, cpu_cmd.ret};
      pc_load_en_reg <= take | pop_stage_reg[0];
      if (pop_stage_reg[0]) pc_load_reg <= mem_rdata;
    end
  end

  // bus answer with read mux; unmapped reads give zero
  wire [31:0] rd_mux =
    (avs_address == `IWC_ADDR_REQ) ? {24'h0, req_reg} :
    (avs_address == `IWC_ADDR_MASK) ? {24'h0, mask_reg} :
    (avs_address == `IWC_ADDR_EDGE) ? {24'h0, edge_reg} :
    (avs_address == `IWC_ADDR_AUX) ? {24'h0, aux_reg} :
    (avs_address == `IWC_ADDR_SP) ? {24'h0, sp_reg} :
    (avs_address == `IWC_ADDR_STAT) ? {27'h0, gie_reg, pwr_reg} :
    (avs_address == `IWC_ADDR_DIE) ? 32'(die_reg) : 32'h0;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0;
    end else begin
      ack_reg <= bus_req;
      wait_reg <= ~bus_req; // output straight from a flop, inverse of ack
      if (bus_req && avs_read) rdata_reg <= rd_mux;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign irq_take = irq_take_reg;
  assign vector_pc = pc_load_reg;
  assign mem_wr = mem_wr_reg;
  assign mem_raddr = mem_raddr_reg;
  assign pc_load = pc_load_reg;
  assign pc_load_en = pc_load_en_reg;
endmodule

// ---- pkg/iwc_cfg.svh ----
`ifndef IWC_CFG_SVH
`define IWC_CFG_SVH
// avalon register word addresses (byte address = index * 4)
`define IWC_ADDR_REQ 4'h0
`define IWC_ADDR_MASK 4'h1
`define IWC_ADDR_EDGE 4'h2
`define IWC_ADDR_AUX 4'h3
`define IWC_ADDR_SP 4'h4
`define IWC_ADDR_STAT 4'h5
`define IWC_ADDR_DIE 4'h6
// field positions
`define IWC_AUX_FAST_BIT 5
`define IWC_MASK_TMR2_BIT 6
`define IWC_MASK_LED_PWM_GENERATOR_BIT 5
`define IWC_MASK_CMP_BIT 4
// edge select codes per pin; the other two codes mean both edges
`define IWC_EDGE_RISE 2'h1
`define IWC_EDGE_FALL 2'h2
// vector and stack step
`define IWC_VECTOR 16'h0010
`define IWC_SP_STEP 8'h02
// wake-up delays in low-speed oscillator periods
`define IWC_WAKE_NORMAL 12'hbb8
`define IWC_WAKE_FAST 12'h02d
// reset values
`define IWC_RST_AUX 8'h00
`define IWC_RST_SP 8'h00
`endif

// ---- pkg/iwc_pkg.sv ----
package iwc_pkg;
  // processor core instruction strobes
  typedef struct packed {
    logic take_ack;
    logic global_on;
    logic global_off;
    logic ret;
    logic push_flags;
    logic pop_flags;
    logic power_save;
    logic power_down;
  } iwc_cpu_cmd_t;
  // memory write request towards data memory
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } iwc_mem_wr_t;
  // power state machine, one-hot
  typedef enum logic [3:0] {
    IWC_ON = 4'b0001,
    IWC_SAVE = 4'b0010,
    IWC_DOWN = 4'b0100,
    IWC_WAKE = 4'b1000
  } iwc_pwr_t;
endpackage

// ---- testbench/iwc_cpu_model.sv ----
// core stand-in: stack memory, program counter, instruction strobes
module iwc_cpu_model (
  // clock
  input wire logic clock,
  // controller side
  input wire iwc_pkg::iwc_mem_wr_t mem_wr,
  input wire logic [7:0] mem_raddr,
  input wire logic [15:0] pc_load,
  input wire logic pc_load_en,
  // core outputs
  output iwc_pkg::iwc_cpu_cmd_t cpu_cmd,
  output logic [15:0] cpu_pc,
  output logic [7:0] cpu_acc,
  output logic [7:0] cpu_flags,
  output logic [15:0] mem_rdata
);
  import iwc_pkg::*;
  logic [7:0] mem [256];
  initial begin
    cpu_cmd = '0;
    cpu_pc = 16'h1234;
  end
  assign cpu_acc = 8'ha5;
  assign cpu_flags = 8'h3c;
  // little-endian words, low byte at the lower address
  assign mem_rdata = {mem[mem_raddr + 8'h01], mem[mem_raddr]};
  // pc moves only on a load, so a wake leaves it after the sleep
  always @(posedge clock) begin
    if (mem_wr.we) begin
      mem[mem_wr.addr] <= mem_wr.data;
    end
    if (pc_load_en) begin
      cpu_pc <= pc_load;
    end
  end
  // one strobe, one cycle long
  task automatic exec(input logic [7:0] c);
    @(posedge clock);
    cpu_cmd <= iwc_cpu_cmd_t'(c);
    @(posedge clock);
    cpu_cmd <= '0;
  endtask
endmodule

// ---- testbench/iwc_ctrl_properties.sv ----
`include "iwc_cfg.svh"
// port-level checks of the controller
module iwc_ctrl_properties (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // core side
  input wire iwc_pkg::iwc_cpu_cmd_t cpu_cmd,
  input wire logic [15:0] cpu_pc,
  input wire logic [15:0] mem_rdata,
  input wire logic irq_take,
  input wire iwc_pkg::iwc_mem_wr_t mem_wr,
  input wire logic [15:0] pc_load,
  input wire logic pc_load_en,
  // power
  input wire logic sys_clk_en,
  input wire logic osc_en,
  input wire logic prog_mem_on
);
  import iwc_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // pc low byte, then high byte one address up
  sequence stack_save;
    mem_wr.we && mem_wr.data == $past(cpu_pc[7:0]) ##1 mem_wr.we &&
    mem_wr.addr == $past(mem_wr.addr) + 8'h01 && mem_wr.data == $past(cpu_pc[15:8], 2);
  endsequence
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  take_vector_a: assert property (irq_take |-> pc_load_en && pc_load == `IWC_VECTOR)
    else $error("interrupt entry not at vector");
  take_cause_a: assert property (irq_take |-> $past(cpu_cmd.take_ack))
    else $error("interrupt taken off a boundary");
  take_stack_a: assert property (irq_take |-> stack_save)
    else $error("pc not pushed to stack");
  gie_clear_a: assert property (irq_take |=> !irq_take)
    else $error("second entry while global enable should be off");
  ret_load_a: assert property (cpu_cmd.ret |-> ##2 pc_load_en && pc_load == $past(mem_rdata))
    else $error("return did not reload pc from stack");
  save_clocks_a: assert property (cpu_cmd.power_save |=> !sys_clk_en && osc_en && !prog_mem_on)
    else $error("power-save clock state wrong");
  down_clocks_a: assert property (cpu_cmd.power_down |=> !sys_clk_en && !osc_en && !prog_mem_on)
    else $error("power-down clock state wrong");
endmodule

bind iwc_ctrl iwc_ctrl_properties u_iwc_ctrl_properties (.clock, .rstn, .avs_read, .avs_write,
  .avs_waitrequest, .cpu_cmd, .cpu_pc, .mem_rdata, .irq_take, .mem_wr, .pc_load, .pc_load_en,
  .sys_clk_en, .osc_en, .prog_mem_on);

// ---- testbench/tb_top.sv ----
`include "iwc_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import iwc_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] ext_pin = 2'h0;
  logic [1:0] wake_pin = 2'h0;
  logic [4:0] ev = 5'h00; // t16, cmp, led_pwm_generator, t2, t3
  logic lrc_tick = 1'b0;
  iwc_cpu_cmd_t cpu_cmd;
  iwc_mem_wr_t mem_wr;
  logic [15:0] cpu_pc, mem_rdata, pc_load;
  logic [7:0] cpu_acc, cpu_flags, mem_raddr, rd;
  logic irq_take, pc_load_en, sys_clk_en, osc_en, prog_mem_on;
  logic [15:0] vector_pc;
  logic timers_run_lrc;
  int miscompares = 0;
  int n_checks = 0;
  int n;
  iwc_ctrl #(.NPIN(2), .FAST_BOOT(1'b0), .WAKE_W(12)) u_iwc_ctrl (.clock, .rstn, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
    .avs_waitrequest, .ext_pin, .wake_pin, .t16_event(ev[4]), .cmp_event(ev[3]),
    .led_pwm_generator_event(ev[2]), .t2_event(ev[1]), .t3_event(ev[0]), .lrc_tick, .cpu_cmd, .cpu_pc,
    .cpu_acc, .cpu_flags, .mem_rdata, .irq_take, .vector_pc, .mem_wr, .mem_raddr, .pc_load,
    .pc_load_en, .sys_clk_en, .osc_en, .prog_mem_on, .timers_run_lrc);
  iwc_cpu_model u_iwc_cpu_model (.clock, .mem_wr, .mem_raddr, .pc_load, .pc_load_en, .cpu_cmd,
    .cpu_pc, .cpu_acc, .cpu_flags, .mem_rdata);
  // clocks; the low-speed tick comes every second clock so a 3000-tick wake stays short
  always #20 clock = ~clock;
  always @(posedge clock) lrc_tick <= ~lrc_tick;
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h0, d};
    @(posedge clock);
    while (avs_waitrequest) @(posedge clock);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check($sformatf("reg %0h", a), {8'h0, rd}, {8'h0, exp});
  endtask
  task automatic cmd(input logic [7:0] c);
    u_iwc_cpu_model.exec(c);
  endtask
  task automatic pulse(input logic [4:0] e);
    @(posedge clock);
    ev <= e;
    @(posedge clock);
    ev <= 5'h00;
  endtask
  // ticks seen from the wake event until the system clock returns
  task automatic wake_ticks(output int t);
    t = 0;
    while (sys_clk_en !== 1'b1) begin
      @(posedge clock);
      if (lrc_tick) t++;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog well beyond the slow wake
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    rdc(`IWC_ADDR_AUX, `IWC_RST_AUX);
    rdc(`IWC_ADDR_SP, `IWC_RST_SP);
    rdc(`IWC_ADDR_STAT, 8'h01);
    bus(1'b1, 4'hf, 8'h55);
    rdc(4'hf, 8'h00);
    $display("test reset done");
    bus(1'b1, `IWC_ADDR_EDGE, 8'h09); // pin0 rising, pin1 falling
    ext_pin <= 2'b11;
    repeat (4) @(posedge clock);
    rdc(`IWC_ADDR_REQ, 8'h01);
    ext_pin <= 2'b00;
    repeat (4) @(posedge clock);
    rdc(`IWC_ADDR_REQ, 8'h03);
    bus(1'b1, `IWC_ADDR_REQ, 8'h00);
    bus(1'b1, `IWC_ADDR_EDGE, 8'h0c); // pin0 code 00, pin1 code 11: both edges
    ext_pin <= 2'b11;
    repeat (4) @(posedge clock);
    rdc(`IWC_ADDR_REQ, 8'h03);
    bus(1'b1, `IWC_ADDR_REQ, 8'h00);
    ext_pin <= 2'b00;
    repeat (4) @(posedge clock);
    rdc(`IWC_ADDR_REQ, 8'h03);
    pulse(5'h1f);
    rdc(`IWC_ADDR_REQ, 8'h7f);
    bus(1'b1, `IWC_ADDR_REQ, 8'h40);
    rdc(`IWC_ADDR_REQ, 8'h40);
    $display("test flags done");
    bus(1'b1, `IWC_ADDR_SP, 8'h20);
    bus(1'b1, `IWC_ADDR_MASK, 8'h40);
    rdc(`IWC_ADDR_MASK, 8'h40);
    cmd(8'h80);
    rdc(`IWC_ADDR_SP, 8'h20);
    cmd(8'h40);
    rdc(`IWC_ADDR_STAT, 8'h11);
    cmd(8'h80);
    rdc(`IWC_ADDR_SP, 8'h22);
    rdc(`IWC_ADDR_STAT, 8'h01);
    check("pc", cpu_pc, `IWC_VECTOR);
    check("vector", vector_pc, `IWC_VECTOR);
    check("stack", {u_iwc_cpu_model.mem[8'h21], u_iwc_cpu_model.mem[8'h20]}, 16'h1234);
    cmd(8'h10);
    rdc(`IWC_ADDR_SP, 8'h20);
    rdc(`IWC_ADDR_STAT, 8'h11);
    check("pc", cpu_pc, 16'h1234);
    bus(1'b1, `IWC_ADDR_MASK, 8'h00);
    cmd(8'h80);
    rdc(`IWC_ADDR_SP, 8'h20);
    cmd(8'h08);
    rdc(`IWC_ADDR_SP, 8'h22);
    check("push", {u_iwc_cpu_model.mem[8'h21], u_iwc_cpu_model.mem[8'h20]}, 16'h3ca5);
    cmd(8'h04);
    rdc(`IWC_ADDR_SP, 8'h20);
    cmd(8'h20);
    rdc(`IWC_ADDR_STAT, 8'h01);
    $display("test interrupt done");
    bus(1'b1, `IWC_ADDR_DIE, 8'h01);
    bus(1'b1, `IWC_ADDR_AUX, 8'h20);
    cmd(8'h02);
    pulse(5'h10);
    wake_ticks(n);
    check("fast wake", {15'h0, n >= 45 && n <= 48}, 16'h0001);
    bus(1'b1, `IWC_ADDR_AUX, 8'h00);
    cmd(8'h01);
    pulse(5'h10);
    wake_pin <= 2'b10;
    repeat (20) @(posedge clock);
    check("asleep", {14'h0, sys_clk_en, osc_en}, 16'h0000);
    check("timers", {15'h0, timers_run_lrc}, 16'h0000);
    wake_pin <= 2'b11;
    wake_ticks(n);
    check("normal wake", {15'h0, n >= 3000 && n <= 3003}, 16'h0001);
    check("pc", cpu_pc, 16'h1234);
    $display("test power done");
    stop_test();
  end
endmodule
